// ===== hw/sfsw_top.sv
// serial flash command front end: status write, protection, single/fast/dual reads
// assumes the host clocks sclk_i only while cs_n_i is low, keeps select high
// at least four system clocks between frames, and that rd_data_i is the
// array byte at rd_addr_o, settled within half a serial clock
`timescale 1ns/10ps
`include "sfsw_defines.svh"
module sfsw_top
    import sfsw_pkg::*;
#(
    parameter int ADDR_W = 22,
    parameter int BLK_W = 16,
    parameter int WCYC_NS = `SFSW_WCYC_NS
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic data_line0_i,
    output logic data_line0_o,
    output logic data_line0_oe_n_o,
    input wire logic data_line1_i,
    output logic data_line1_o,
    output logic data_line1_oe_n_o,
    input wire logic protect_pin_or_data2_i,
    input wire logic data_line3_i,
    input wire logic quad_command_mode_i,
    output logic [ADDR_W-1:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    input wire logic [ADDR_W-1:0] pe_addr_i,
    output logic pe_blocked_o,
    output logic [7:0] status_o,
    output logic [7:0] config_o,
    output logic prot_mode_o,
    output logic sw_reject_o
);
    localparam int WCYC_CYC = (WCYC_NS + `SFSW_CLK_NS - 1) / `SFSW_CLK_NS;
    localparam int WCYC_W = $clog2(WCYC_CYC + 1);

    // system domain state
    logic lock_q, quad_en_q, wr_latch_q, busy_q, tb_q, prot_q;
    logic [3:0] bp_q;
    logic [1:0] dc_q;
    logic [2:0] ods_q;
    logic [WCYC_W-1:0] wcyc_q;
    logic cs_s1_q, cs_s2_q, cs_s3_q, wp_s1_q, wp_s2_q;
    logic tg_s1_q, tg_s2_q, seen_q;
    // link domain state
    logic fresh_q, tgl_q;
    sfsw_phase_e ph_q;
    logic [4:0] cnt_q, wbits_q;
    logic [7:0] sh_q, cmd_q, sbyte_q, cbyte_q;
    logic [23:0] addr_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic [3:0] lk_s1_q, lk_s2_q;
    logic d0_q, d1_q, oe0_n_q, oe1_n_q;

    // ---------------- link domain ----------------
    // new frame marker, raised while select is high
    always_ff @(posedge sclk_i or posedge cs_n_i or posedge rst_i) begin
        if (rst_i) begin
            fresh_q <= 1'b1;
        end else if (cs_n_i) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // {busy, quad command mode, dummy bits} carried over to the link clock
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            lk_s1_q <= 4'h0;
            lk_s2_q <= 4'h0;
        end else begin
            lk_s1_q <= {busy_q, quad_command_mode_i, dc_q};
            lk_s2_q <= lk_s1_q;
        end
    end

    logic lk_busy, qm, dual;
    sfsw_phase_e ph;
    logic [4:0] cnt, step, cnt_n, wbits, wbits_n, dummy_n;
    logic [7:0] sh_n;
    logic [23:0] addr_n;
    logic [3:0] obit_n;
    assign lk_busy = lk_s2_q[3];
    assign qm = lk_s2_q[2];
    assign dual = (cmd_q == `SFSW_CMD_DUAL_RD);
    assign ph = fresh_q ? SFSW_CMD : ph_q;
    assign cnt = fresh_q ? 5'h00 : cnt_q;
    assign step = qm ? `SFSW_STEP_QUAD : `SFSW_STEP_SPI; // RL7
    assign cnt_n = cnt + step;
    // upper lines only matter in quad command mode
    assign sh_n = qm ? {sh_q[3:0], data_line3_i, protect_pin_or_data2_i, data_line1_i,
                        data_line0_i} : {sh_q[6:0], data_line0_i}; // RL7
    assign addr_n = {addr_q[22:0], data_line0_i};
    assign obit_n = {1'b0, cnt[2:0]} + (dual ? 4'h2 : 4'h1); // RL20
    assign wbits = fresh_q ? 5'h00 : wbits_q;
    assign wbits_n = (wbits >= `SFSW_WB_MAX - step) ? `SFSW_WB_MAX : wbits + step;

    always_comb begin
        case (lk_s2_q[1:0]) // RL22
            2'h0: dummy_n = `SFSW_DUMMY_00;
            2'h1: dummy_n = `SFSW_DUMMY_01;
            2'h2: dummy_n = `SFSW_DUMMY_10;
            default: dummy_n = `SFSW_DUMMY_11;
        endcase
    end

    // phase sequencer, sampled on rising serial clock
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_q <= SFSW_CMD;
            cnt_q <= 5'h00;
            sh_q <= 8'h00;
            cmd_q <= 8'h00;
            tgl_q <= 1'b0;
        end else begin
            sh_q <= sh_n;
            cnt_q <= cnt_n;
            case (ph)
                SFSW_CMD: begin
                    if (cnt_n == `SFSW_BYTE_BITS) begin // RL7
                        cmd_q <= sh_n;
                        tgl_q <= ~tgl_q;
                        cnt_q <= 5'h00;
                        case (sh_n)
                            `SFSW_CMD_READ, `SFSW_CMD_FREAD, `SFSW_CMD_DUAL_RD: begin
                                // reads are single-line only and refused while busy
                                ph_q <= (lk_busy || qm) ? SFSW_SKIP : SFSW_ADDR; // RL18
                            end
                            `SFSW_CMD_STAT_WR: ph_q <= SFSW_WDATA; // RL4
                            default: ph_q <= SFSW_SKIP;
                        endcase
                    end else begin
                        ph_q <= SFSW_CMD;
                    end
                end
                SFSW_ADDR: begin
                    if (cnt_n == `SFSW_ADDR_BITS) begin // RL16
                        cnt_q <= 5'h00;
                        ph_q <= (cmd_q == `SFSW_CMD_READ) ? SFSW_DATA : SFSW_DUMMY;
                    end
                end
                SFSW_DUMMY: begin
                    if (cnt_n == dummy_n) begin // RL19
                        cnt_q <= 5'h00;
                        ph_q <= SFSW_DATA;
                    end
                end
                SFSW_DATA: cnt_q <= {2'b00, obit_n[2:0]};
                SFSW_WDATA: ph_q <= SFSW_WDATA;
                SFSW_SKIP: ph_q <= SFSW_SKIP;
                default: ph_q <= SFSW_SKIP;
            endcase
        end
    end

    // address capture and byte-wise increment with wrap
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_q <= 24'h000000;
            rd_addr_q <= '0;
        end else if (ph == SFSW_ADDR) begin
            addr_q <= addr_n; // RL16
            if (cnt_n == `SFSW_ADDR_BITS) begin
                rd_addr_q <= addr_n[ADDR_W-1:0];
            end
        end else if (ph == SFSW_DATA && obit_n[3]) begin
            rd_addr_q <= rd_addr_q + 1'b1; // RL17
        end
    end

    // status and configuration bytes of a status write
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            wbits_q <= 5'h00;
            sbyte_q <= 8'h00;
            cbyte_q <= 8'h00;
        end else if (ph == SFSW_WDATA) begin
            wbits_q <= wbits_n; // RL5
            if (wbits_n == `SFSW_WR_SHORT) begin
                sbyte_q <= sh_n; // RL4
            end
            if (wbits_n == `SFSW_WR_LONG) begin
                cbyte_q <= sh_n; // RL4
            end
        end else if (ph == SFSW_CMD) begin
            wbits_q <= 5'h00;
        end
    end

    // output drivers change on falling serial clock, released by select
    always_ff @(negedge sclk_i or posedge cs_n_i or posedge rst_i) begin
        if (rst_i) begin
            d0_q <= 1'b0;
            d1_q <= 1'b0;
            oe0_n_q <= 1'b1;
            oe1_n_q <= 1'b1;
        end else if (cs_n_i) begin
            d0_q <= 1'b0; // RL21
            d1_q <= 1'b0;
            oe0_n_q <= 1'b1;
            oe1_n_q <= 1'b1;
        end else begin
            oe1_n_q <= ~(!fresh_q && ph_q == SFSW_DATA); // RL16
            oe0_n_q <= ~(!fresh_q && ph_q == SFSW_DATA && dual); // RL20
            d1_q <= rd_data_i[3'h7 - cnt_q[2:0]];
            d0_q <= rd_data_i[3'h6 - cnt_q[2:0]]; // RL20
        end
    end

    // ---------------- system domain ----------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
            tg_s1_q <= 1'b0;
            tg_s2_q <= 1'b0;
        end else begin
            cs_s1_q <= cs_n_i;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= protect_pin_or_data2_i;
            wp_s2_q <= wp_s1_q;
            tg_s1_q <= tgl_q;
            tg_s2_q <= tg_s1_q;
        end
    end

    logic exec, wr_len_ok, wr_ok, wcyc_done;
    // link bytes are stable here: the serial clock stands still after select rises
    assign exec = cs_s2_q && !cs_s3_q && (tg_s2_q != seen_q);
    assign wr_len_ok = (wbits_q == `SFSW_WR_SHORT) || (wbits_q == `SFSW_WR_LONG); // RL5
    assign wr_ok = exec && (cmd_q == `SFSW_CMD_STAT_WR) && wr_latch_q && !prot_q && !busy_q
                   && wr_len_ok; // RL1 RL3 RL10
    assign wcyc_done = busy_q && (wcyc_q == WCYC_W'(1));

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            seen_q <= 1'b0;
        end else if (cs_s2_q && !cs_s3_q) begin
            seen_q <= tg_s2_q;
        end
    end

    // protection: lock set with pin low, unless any quad mode is on
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prot_q <= 1'b0;
        end else begin
            prot_q <= lock_q && !wp_s2_q
                      && !quad_en_q && !quad_command_mode_i; // RL11 RL12 RL13 RL24
        end
    end

    // self-timed write cycle
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            wcyc_q <= '0;
        end else if (wr_ok) begin
            busy_q <= 1'b1; // RL6
            wcyc_q <= WCYC_W'(WCYC_CYC);
        end else if (wcyc_done) begin
            busy_q <= 1'b0; // RL6
            wcyc_q <= '0;
        end else if (busy_q) begin
            wcyc_q <= wcyc_q - 1'b1;
        end
    end

    // write enable latch; a new set wins over the end-of-cycle clear
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_latch_q <= 1'b0;
        end else if (exec && cmd_q == `SFSW_CMD_WR_EN) begin
            wr_latch_q <= 1'b1; // RL8 RL9
        end else if (wcyc_done) begin
            wr_latch_q <= 1'b0; // RL6
        end else if (exec && cmd_q == `SFSW_CMD_WR_DIS && !busy_q) begin
            wr_latch_q <= 1'b0;
        end
    end

    // status and configuration update, latch and busy never taken from data
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lock_q <= 1'b0;
            quad_en_q <= 1'b0;
            bp_q <= 4'h0;
            dc_q <= 2'h0;
            tb_q <= 1'b0;
            ods_q <= `SFSW_ODS_RST;
        end else if (wr_ok) begin
            lock_q <= sbyte_q[`SFSW_SR_LOCK]; // RL2 RL8 RL9
            quad_en_q <= sbyte_q[`SFSW_SR_QUAD];
            bp_q <= sbyte_q[`SFSW_SR_BP_HI:`SFSW_SR_BP_LO];
            if (wbits_q == `SFSW_WR_LONG) begin // RL25
                dc_q <= cbyte_q[`SFSW_CR_DC_HI:`SFSW_CR_DC_LO];
                tb_q <= tb_q | cbyte_q[`SFSW_CR_TB];
                ods_q <= cbyte_q[`SFSW_CR_ODS_HI:`SFSW_CR_ODS_LO];
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sw_reject_o <= 1'b0;
        end else begin
            sw_reject_o <= exec && (cmd_q == `SFSW_CMD_STAT_WR) && !wr_ok; // RL5 RL10
        end
    end

    // protected region: size doubles per protect level from the top or bottom
    localparam logic [ADDR_W:0] FULL = (ADDR_W+1)'(1) << ADDR_W;
    logic [ADDR_W:0] psize;
    always_comb begin
        if (bp_q == 4'h0) begin
            psize = '0;
        end else if (int'(bp_q) - 1 >= ADDR_W - BLK_W) begin
            psize = FULL;
        end else begin
            psize = (ADDR_W+1)'(1) << (BLK_W + int'(bp_q) - 1);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pe_blocked_o <= 1'b0;
        end else if (tb_q) begin
            pe_blocked_o <= ({1'b0, pe_addr_i} < psize); // RL14
        end else begin
            pe_blocked_o <= ({1'b0, pe_addr_i} >= FULL - psize); // RL14
        end
    end

    assign status_o = {lock_q, quad_en_q, bp_q, wr_latch_q, busy_q}; // RL23
    assign config_o = {dc_q, 2'b00, tb_q, ods_q};
    assign prot_mode_o = prot_q;
    assign rd_addr_o = rd_addr_q;
    assign data_line0_o = d0_q;
    assign data_line0_oe_n_o = oe0_n_q;
    assign data_line1_o = d1_q;
    assign data_line1_oe_n_o = oe1_n_q;
endmodule

// ===== inc/sfsw_defines.svh
// constants of the serial flash status-write and read command front end
// assumes inclusion by the top module; pairs with sfsw_pkg for the types
// Functional notes
// RL1: status write needs write enable latch set
// RL2: status write leaves latch and busy untouched
// RL3: hardware protected mode refuses status write
// RL4: host sends command, status, optional config byte
// RL5: select rises after 8 or 16 bits
// RL6: select rise starts timed cycle, then clear
// RL7: command byte serial or quad nibbles
// RL8: lock clear: latch and writes always allowed
// RL9: lock set, pin high: writes still allowed
// RL10: lock set, pin low: every write refused
// RL11: lock set and pin low enter protection
// RL12: leave protection only when pin rises; code also leaves it while quad command mode is on
// RL13: quad mode or quad enable disable protection
// RL14: protected region blocks program and erase
// RL15: host keeps pin high during locked write
// RL16: plain read: command, 3 address bytes, data
// RL17: address increments per byte, wraps to zero
// RL18: reads refused while a write cycle runs
// RL19: fast read inserts dummy clocks before data
// RL20: dual read outputs two bits per clock
// RL21: select rise ends read, output released
// RL22: dummy count follows two configuration bits
// RL23: status byte layout lock,quad,protect,latch,busy
// RL24: quad enable clear: pin is protect input
// RL25: eight-bit write keeps configuration byte
`ifndef SFSW_DEFINES_SVH
`define SFSW_DEFINES_SVH
`define SFSW_CMD_STAT_WR 8'h01
`define SFSW_CMD_READ 8'h03
`define SFSW_CMD_WR_DIS 8'h04
`define SFSW_CMD_WR_EN 8'h06
`define SFSW_CMD_FREAD 8'h0b
`define SFSW_CMD_DUAL_RD 8'h3b
`define SFSW_BYTE_BITS 5'h08
`define SFSW_ADDR_BITS 5'h18
`define SFSW_WR_SHORT 5'h08
`define SFSW_WR_LONG 5'h10
`define SFSW_WB_MAX 5'h1f
`define SFSW_STEP_SPI 5'h01
`define SFSW_STEP_QUAD 5'h04
`define SFSW_DUMMY_00 5'h08
`define SFSW_DUMMY_01 5'h06
`define SFSW_DUMMY_10 5'h08
`define SFSW_DUMMY_11 5'h0a
`define SFSW_SR_LOCK 7
`define SFSW_SR_QUAD 6
`define SFSW_SR_BP_HI 5
`define SFSW_SR_BP_LO 2
`define SFSW_CR_DC_HI 7
`define SFSW_CR_DC_LO 6
`define SFSW_CR_TB 3
`define SFSW_CR_ODS_HI 2
`define SFSW_CR_ODS_LO 0
`define SFSW_ODS_RST 3'h7
`define SFSW_CLK_NS 8
`define SFSW_WCYC_NS 40000
`endif

// ===== inc/sfsw_pkg.sv
// types of the serial flash status-write and read command front end
// assumes nothing beyond a SystemVerilog compiler
package sfsw_pkg;
    typedef enum logic [2:0] {
        SFSW_CMD,
        SFSW_ADDR,
        SFSW_DUMMY,
        SFSW_DATA,
        SFSW_WDATA,
        SFSW_SKIP
    } sfsw_phase_e;
endpackage

// ===== tb/sfsw_host_model.sv
// host side of the serial link: framed command, address and data bits
// assumes the caller waits for each frame to finish before the next
`timescale 1ns/10ps
module sfsw_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic data_line0_o,
    input wire logic data_line0_i,
    input wire logic data_line1_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        data_line0_o = 1'b0;
    end
    // no bits out msb first, then nr clocks capturing both lines
    task automatic frame(input logic [39:0] ob, input int no, input int nr,
            output logic [31:0] r1, output logic [31:0] r0);
        int i;
        r1 = 32'h0;
        r0 = 32'h0;
        #3 cs_n_o = 1'b0;
        for (i = 0; i < no + nr; i++) begin
            data_line0_o = (i < no) ? ob[no - 1 - i] : ~data_line0_o;
            #32 sclk_o = 1'b1;
            if (i >= no) begin
                r1 = {r1[30:0], data_line1_i};
                r0 = {r0[30:0], data_line0_i};
            end
            #32 sclk_o = 1'b0;
        end
        #32 cs_n_o = 1'b1;
        data_line0_o = ~data_line0_o;
        #40;
    endtask
endmodule

// ===== tb/sfsw_top_properties.sv
// assertions on the ports of the status-write and read front end
// assumes binding into sfsw_top with the instance's WCYC_NS
`timescale 1ns/10ps
module sfsw_top_properties #(
    parameter int WCYC_NS = 40000
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic data_line0_oe_n_o,
    input wire logic data_line1_oe_n_o,
    input wire logic protect_pin_or_data2_i,
    input wire logic quad_command_mode_i,
    input wire logic pe_blocked_o,
    input wire logic [7:0] status_o,
    input wire logic prot_mode_o,
    input wire logic sw_reject_o
);
    // write cycle length in system clocks, rounded up like the design
    localparam int WCYC_CYC = (WCYC_NS + 7) / 8;
    int busy_cnt_q;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // cycles the busy flag has stood high so far
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            busy_cnt_q <= 0;
        end else if (status_o[0]) begin
            busy_cnt_q <= busy_cnt_q + 1;
        end else begin
            busy_cnt_q <= 0;
        end
    end
    sequence s_locked_low;
        status_o[7] && !status_o[6] && !quad_command_mode_i && !protect_pin_or_data2_i;
    endsequence
    sequence s_pin_high;
        protect_pin_or_data2_i [*4];
    endsequence
    a_prot_entry: assert property (s_locked_low [*4] |-> prot_mode_o)
        else $error("protected mode not entered");
    a_prot_exit: assert property (s_pin_high |-> !prot_mode_o)
        else $error("protected mode kept with pin high");
    a_quad_off: assert property ((quad_command_mode_i || status_o[6]) [*3] |-> !prot_mode_o)
        else $error("protected mode in quad operation");
    a_prot_frozen: assert property (prot_mode_o [*2] |=> $stable(status_o[7:2]))
        else $error("status changed in protected mode");
    a_needs_latch: assert property ($changed(status_o[7:2]) |-> $past(status_o[1]))
        else $error("status written without write enable");
    a_busy_time: assert property ($fell(status_o[0]) |-> !status_o[1]
        && busy_cnt_q >= WCYC_CYC - 3 && busy_cnt_q <= WCYC_CYC + 3)
        else $error("write cycle length or latch clear wrong");
    a_reject_end: assert property (sw_reject_o |-> cs_n_i ##1 !sw_reject_o)
        else $error("reject pulse malformed");
    a_oe_release: assert property (cs_n_i |-> data_line1_oe_n_o && data_line0_oe_n_o)
        else $error("output driven while deselected");
    a_pe_none: assert property ((status_o[5:2] == 4'h0) [*2] |-> !pe_blocked_o)
        else $error("blocked with no protected region");
endmodule

bind sfsw_top sfsw_top_properties #(.WCYC_NS(WCYC_NS)) sfsw_top_properties_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
    .data_line0_oe_n_o(data_line0_oe_n_o), .data_line1_oe_n_o(data_line1_oe_n_o),
    .protect_pin_or_data2_i(protect_pin_or_data2_i),
    .quad_command_mode_i(quad_command_mode_i), .pe_blocked_o(pe_blocked_o),
    .status_o(status_o), .prot_mode_o(prot_mode_o), .sw_reject_o(sw_reject_o)
);

// ===== tb/sfsw_top_tb.sv
// self-checking bench for the status-write and read front end
// assumes the host model drives the link; array byte is address xor a5
`timescale 1ns/10ps
module sfsw_top_tb;
    localparam int WCYC = 2000;
    localparam int DMY[4] = '{8, 6, 8, 10};
    logic clk_sys_i = 1'b0, rst_i = 1'b1, pin = 1'b1, quad = 1'b0;
    logic pat = 1'b0, rej_seen = 1'b0, oe_seen = 1'b0;
    logic [21:0] pe_addr = 22'h000000;
    logic [21:0] rd_addr;
    logic [7:0] status, cfg;
    logic line0_o, oe0_n, line1_o, oe1_n, blk, prot, rej;
    logic [31:0] r1, r0;
    int n_fail = 0, checked = 0, cyc = 0;
    wire sclk, cs_n, mosi;
    wire line0 = oe0_n ? mosi : line0_o;
    wire line1 = oe1_n ? pat : line1_o;
    wire [7:0] rd_data = rd_addr[7:0] ^ 8'ha5;
    sfsw_top #(.WCYC_NS(WCYC)) sfsw_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .sclk_i(sclk), .cs_n_i(cs_n), .data_line0_i(line0), .data_line0_o(line0_o),
        .data_line0_oe_n_o(oe0_n), .data_line1_i(line1), .data_line1_o(line1_o),
        .data_line1_oe_n_o(oe1_n), .protect_pin_or_data2_i(pin), .data_line3_i(1'b0),
        .quad_command_mode_i(quad), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
        .pe_addr_i(pe_addr), .pe_blocked_o(blk), .status_o(status), .config_o(cfg),
        .prot_mode_o(prot), .sw_reject_o(rej));
    sfsw_host_model sfsw_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .data_line0_o(mosi),
        .data_line0_i(line0), .data_line1_i(line1));
    initial forever #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        pat <= ~pat;
        if (rej === 1'b1) rej_seen <= 1'b1;
        if (oe1_n === 1'b0) oe_seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            print_verdict();
        end
    end
    function automatic logic [7:0] byte_at(input logic [21:0] a);
        return a[7:0] ^ 8'ha5;
    endfunction
    function automatic logic [3:0] pick(input logic [7:0] b, input int o);
        return {b[6 + o], b[4 + o], b[2 + o], b[o]};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic xfer(input logic [39:0] ob, input int no, input int nr);
        sfsw_host_model_i.frame(ob, no, nr, r1, r0);
        idle(6);
    endtask
    task automatic stat_wr(input logic [15:0] d, input int nb);
        xfer(40'h06, 8, 0);
        rej_seen = 1'b0;
        xfer(40'({8'h01, d}) >> (16 - nb), 8 + nb, 0);
    endtask
    task automatic settle();
        int i;
        for (i = 0; i < 400 && status[0] !== 1'b0; i++)
            @(negedge clk_sys_i);
        chk("wip_wel_end", 2'h0, status[1:0]);
    endtask
    task automatic t_reset();
        chk("status_rst", 8'h00, status);
        chk("config_rst", 8'h07, cfg);
        chk("oe_rst", 2'h3, {oe1_n, oe0_n});
    endtask
    task automatic t_status_write_cmd();
        rej_seen = 1'b0;
        xfer(40'h01bc, 16, 0);
        chk("reject_nowel", 1'h1, rej_seen);
        chk("status_nowel", 8'h00, status);
        stat_wr(16'hbcc7, 16);
        chk("status_busy", 8'hbf, status);
        settle();
        chk("status_long", 8'hbc, status);
        chk("config_long", 8'hc7, cfg);
        stat_wr(16'h1234, 12);
        chk("reject_count", 1'h1, rej_seen);
        chk("status_count", 6'h2f, status[7:2]);
        stat_wr(16'h8000, 8);
        chk("reject_short", 1'h0, rej_seen);
        settle();
        chk("status_short", 8'h80, status);
        chk("config_short", 8'hc7, cfg);
    endtask
    task automatic t_prot();
        pe_addr = 22'h3f0000;
        pin = 1'b0;
        idle(6);
        chk("blocked_none", 1'h0, blk);
        chk("prot_enter", 1'h1, prot);
        quad = 1'b1;
        idle(4);
        chk("prot_quad", 1'h0, prot);
        quad = 1'b0;
        idle(4);
        stat_wr(16'h0400, 8);
        chk("reject_prot", 1'h1, rej_seen);
        chk("status_prot", 6'h20, status[7:2]);
        pin = 1'b1;
        idle(6);
        chk("prot_leave", 1'h0, prot);
        stat_wr(16'h0400, 8);
        settle();
        chk("status_unlock", 8'h04, status);
        chk("blocked_top", 1'h1, blk);
        pe_addr = 22'h000000;
        idle(2);
        chk("blocked_low", 1'h0, blk);
    endtask
    task automatic t_reads();
        int i;
        for (i = 0; i < 4; i++) begin
            stat_wr({8'h04, 2'(i), 6'h07}, 16);
            settle();
            oe_seen = 1'b0;
            xfer({16'h000b, 24'h000010}, 32, DMY[i] + 8);
            chk("fast_data", byte_at(22'h000010), r1[7:0]);
            chk("fast_oe", 2'h3, {oe_seen, oe1_n});
        end
        xfer({16'h003b, 24'h000020}, 32, 18);
        chk("dual_odd", {pick(byte_at(22'h20), 1), pick(byte_at(22'h21), 1)}, r1[7:0]);
        chk("dual_even", {pick(byte_at(22'h20), 0), pick(byte_at(22'h21), 0)}, r0[7:0]);
        xfer({16'h0003, 24'h3fffff}, 32, 16);
        chk("plain_wrap", {byte_at(22'h3fffff), byte_at(22'h0)}, r1[15:0]);
    endtask
    task automatic t_busy();
        stat_wr(16'h0407, 16);
        oe_seen = 1'b0;
        xfer({16'h0003, 24'h000000}, 32, 8);
        chk("busy_oe", 1'h0, oe_seen);
        settle();
        chk("busy_config", 8'h07, cfg);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        idle(4);
        t_reset();
        t_status_write_cmd();
        t_prot();
        t_reads();
        t_busy();
        print_verdict();
    end
endmodule
